// file: rtl/alu_control_flags.sv
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module alu_control_flags
  import alu_flags_pkg::*;
#(
  parameter int XLEN = 32
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Instruction request
  input  wire logic              op_valid_i,
  input  wire op_e               op_code_i,
  input  wire logic [XLEN-1:0]   op_a_i,
  input  wire logic [XLEN-1:0]   op_b_i,
  input  wire logic              op_alu_regs_i,
  input  wire logic [XLEN-1:0]   next_ip_i,
  input  wire logic              paging_en_i,
  input  wire logic              page_read_only_i,
  output logic                   op_ready_o,
  output logic                   op_done_o,
  // Results
  output logic                   target_we_o,
  output logic      [XLEN-1:0]   target_data_o,
  output logic                   ext_we_o,
  output logic      [EXT_N-1:0]  ext_sel_o,
  output logic      [XLEN-1:0]   ext_data_o,
  output logic                   ip_load_o,
  output logic      [XLEN-1:0]   ip_value_o,
  // Faults
  output logic                   fault_bad_value_o,
  output logic                   fault_page_perm_o,
  // Memory port for return addresses
  output logic                   mem_req_o,
  output logic                   mem_we_o,
  output logic      [XLEN-1:0]   mem_addr_o,
  output logic      [XLEN-1:0]   mem_wdata_o,
  input  wire logic              mem_ack_i,
  input  wire logic [XLEN-1:0]   mem_rdata_i
);

  localparam int            WW   = 2 * XLEN + 2;
  localparam logic [XLEN-1:0] STEP =
    XLEN'((XLEN == 64) ? STEP_64 : STEP_32);

  if (XLEN != 32 && XLEN != 64) begin : g_chk
    $error("XLEN must be 32 or 64");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [XLEN-1:0] width_mask(
    input logic [31:0] cfg, input logic is_alu);
    width_mask = '1;
    if (is_alu) begin
      if (cfg[W8_BIT])       width_mask = XLEN'(8'hFF);
      else if (cfg[W16_BIT]) width_mask = XLEN'(16'hFFFF);
      else if (cfg[W32_BIT]) width_mask = XLEN'(32'hFFFFFFFF);
    end
  endfunction

  // Sign or zero extension of the masked low bits to full arithmetic width
  function automatic logic signed [WW-1:0] extend(
    input logic [XLEN-1:0] v, input logic [XLEN-1:0] m, input logic sgn);
    logic [XLEN-1:0] hb;
    logic            s;
    hb = m & ~(m >> 1);
    s  = sgn & (|(v & hb));
    extend = {{(WW-XLEN){s}}, (v & m) | (s ? ~m : '0)};
  endfunction

  function automatic logic [31:0] be_merge(
    input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_CALL_MEM, ST_RET_MEM} state_e;

  state_e          state;
  logic [31:0]     cmp_cfg;
  logic [31:0]     logic_cfg;
  logic [31:0]     arith_cfg;
  logic [XLEN-1:0] ret_ptr;
  logic            rd_done;

  logic take;
  logic wr_cmp;
  logic wr_logic;
  logic wr_arith;
  logic page_bad;
  assign op_ready_o = (state == ST_IDLE);
  assign take       = op_valid_i & op_ready_o;
  assign wr_cmp     = avs_write_i & (avs_address_i == OFS_CMP);
  assign wr_logic   = avs_write_i & (avs_address_i == OFS_LOGIC);
  assign wr_arith   = avs_write_i & (avs_address_i == OFS_ARITH);
  assign page_bad   = paging_en_i & ~page_read_only_i;

  // ****************************************************************
  // Compare
  // ****************************************************************
  logic cmp_hit;
  always_comb begin
    cmp_hit = (cmp_cfg[CMP_NE] & (op_a_i != op_b_i))
            | (cmp_cfg[CMP_GT] & (op_a_i >  op_b_i))
            | (cmp_cfg[CMP_LT] & (op_a_i <  op_b_i))
            | (cmp_cfg[CMP_EQ] & (op_a_i == op_b_i));
  end

  // ****************************************************************
  // Logic unit
  // ****************************************************************
  logic [XLEN-1:0] lm;
  logic [XLEN-1:0] logic_res;
  logic            logic_any;
  always_comb begin
    logic [XLEN-1:0] av;
    logic [XLEN-1:0] bv;
    logic [XLEN-1:0] r;
    int              w;
    int              rot;
    av  = '0;
    bv  = '0;
    r   = '0;
    lm  = width_mask(logic_cfg, op_alu_regs_i);
    av  = op_a_i & lm;
    bv  = op_b_i & lm;
    w   = $countones(lm);
    rot = int'(op_b_i & XLEN'(w - 1));
    logic_any = |logic_cfg[LG_ROR:LG_NOT];
    if (logic_cfg[LG_XOR])      r = av ^ bv;
    else if (logic_cfg[LG_AND]) r = av & bv;
    else if (logic_cfg[LG_OR])  r = av | bv;
    else if (logic_cfg[LG_SHL])
      r = (op_b_i >= XLEN'(w)) ? '0 : (av << op_b_i);
    else if (logic_cfg[LG_SHR])
      r = (op_b_i >= XLEN'(w)) ? '0 : (av >> op_b_i);
    else if (logic_cfg[LG_ROL]) r = (av << rot) | (av >> (w - rot));
    else if (logic_cfg[LG_ROR]) r = (av >> rot) | (av << (w - rot));
    else                        r = av;
    if (logic_cfg[LG_NOT] &&
        !(|logic_cfg[LG_ROR:LG_SHL])) begin
      r = ~r;
    end
    logic_res = (op_a_i & ~lm) | (r & lm);
  end

  // ****************************************************************
  // Arithmetic unit
  // ****************************************************************
  logic [XLEN-1:0] am;
  logic [XLEN-1:0] arith_res;
  logic [XLEN-1:0] arith_hi;
  logic            arith_any;
  logic            ext_any;
  logic            ovf;
  logic            unf;
  always_comb begin
    logic signed [WW-1:0] ea;
    logic signed [WW-1:0] eb;
    logic signed [WW-1:0] full;
    logic                 fits;
    am   = width_mask(arith_cfg, op_alu_regs_i);
    ea   = extend(op_a_i, am, arith_cfg[AR_SGN]);
    eb   = extend(op_b_i, am, arith_cfg[AR_SGN]);
    full = '0;
    if (arith_cfg[AR_MUL])      full = ea * eb;
    else if (arith_cfg[AR_DIV]) full = (eb == '0) ? '0 : ea / eb;
    else if (arith_cfg[AR_SUB]) full = ea - eb;
    else if (arith_cfg[AR_ADD]) full = ea + eb;
    else if (arith_cfg[AR_MOD]) full = (eb == '0) ? '0 : ea % eb;
    arith_any = |arith_cfg[AR_MOD:AR_MUL];
    ext_any   = |arith_cfg[AR_EXT +: EXT_N];
    fits      = (extend(full[XLEN-1:0], am, arith_cfg[AR_SGN]) == full);
    ovf       = arith_any & ~ext_any & ~fits & ~full[WW-1];
    unf       = arith_any & ~ext_any & ~fits & full[WW-1];
    // Low bits only: carry or borrow beyond the width is dropped
    arith_res = (op_a_i & ~am) | (full[XLEN-1:0] & am);
    arith_hi  = full[2*XLEN-1:XLEN];
  end

  logic bad_w;
  assign bad_w = (XLEN == 32) & (((op_code_i == OP_LOGIC) &
                 logic_cfg[W32_BIT]) | ((op_code_i == OP_ARITH) &
                 arith_cfg[W32_BIT]));

  // ****************************************************************
  // Sequencer and memory port
  // ****************************************************************
  // Only call and return touch memory; there is no stack opcode at all
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state       <= ST_IDLE;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= '0;
      mem_wdata_o <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take && !page_bad && op_code_i == OP_CALL) begin
            state       <= ST_CALL_MEM;
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b1;
            mem_addr_o  <= ret_ptr;
            mem_wdata_o <= next_ip_i;
          end else if (take && !page_bad && op_code_i == OP_RET) begin
            state       <= ST_RET_MEM;
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= ret_ptr - STEP;
          end
        end
        ST_CALL_MEM, ST_RET_MEM: begin
          if (mem_ack_i) begin
            state     <= ST_IDLE;
            mem_req_o <= 1'b0;
            mem_we_o  <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Result and fault outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_done_o         <= 1'b0;
      target_we_o       <= 1'b0;
      target_data_o     <= '0;
      ext_we_o          <= 1'b0;
      ext_sel_o         <= '0;
      ext_data_o        <= '0;
      ip_load_o         <= 1'b0;
      ip_value_o        <= '0;
      fault_bad_value_o <= 1'b0;
      fault_page_perm_o <= 1'b0;
    end else begin
      op_done_o         <= 1'b0;
      target_we_o       <= 1'b0;
      ext_we_o          <= 1'b0;
      ip_load_o         <= 1'b0;
      fault_bad_value_o <= 1'b0;
      fault_page_perm_o <= 1'b0;
      if (take) begin
        case (op_code_i)
          OP_CALL, OP_RET: begin
            fault_page_perm_o <= page_bad;
            op_done_o         <= page_bad;
          end
          OP_CMP: op_done_o <= 1'b1;
          OP_LOGIC: begin
            op_done_o         <= 1'b1;
            fault_bad_value_o <= bad_w;
            target_we_o       <= ~bad_w & logic_any;
            target_data_o     <= logic_res;
          end
          OP_ARITH: begin
            op_done_o         <= 1'b1;
            fault_bad_value_o <= bad_w;
            target_we_o       <= ~bad_w & arith_any;
            target_data_o     <= arith_res;
            ext_we_o          <= ~bad_w & arith_any & ext_any;
            ext_sel_o         <= arith_cfg[AR_EXT +: EXT_N];
            ext_data_o        <= arith_hi;
          end
          default: op_done_o <= 1'b1;
        endcase
      end else if (state != ST_IDLE && mem_ack_i) begin
        op_done_o <= 1'b1;
        if (state == ST_RET_MEM) begin
          ip_load_o  <= 1'b1;
          ip_value_o <= mem_rdata_i;
        end
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic take_cmp;
  logic take_arith;
  assign take_cmp   = take & (op_code_i == OP_CMP);
  assign take_arith = take & (op_code_i == OP_ARITH) & ~bad_w;

  // The compare outcome wins over a software write landing on bit 0
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmp_cfg <= CFG_RESET;
    end else begin
      logic [31:0] next_cmp;
      next_cmp = cmp_cfg;
      if (wr_cmp) begin
        next_cmp = be_merge(cmp_cfg, avs_writedata_i, avs_byteenable_i)
                 & CMP_WMASK;
      end
      if (take_cmp) next_cmp[CMP_RES] = cmp_hit;
      cmp_cfg <= next_cmp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      logic_cfg <= CFG_RESET;
    end else if (wr_logic) begin
      logic_cfg <= be_merge(logic_cfg, avs_writedata_i, avs_byteenable_i)
                 & LOGIC_WMASK;
    end
  end

  // Flags are sticky; only a software write clears them, and a new event
  // in that same cycle still sets them
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      arith_cfg <= CFG_RESET;
    end else begin
      logic [31:0] next_arith;
      next_arith = arith_cfg;
      if (wr_arith) begin
        next_arith = be_merge(arith_cfg, avs_writedata_i,
                              avs_byteenable_i) & ARITH_WMASK;
      end
      if (take_arith) begin
        next_arith[AR_OVF] = next_arith[AR_OVF] | ovf;
        next_arith[AR_UNF] = next_arith[AR_UNF] | unf;
      end
      arith_cfg <= next_arith;
    end
  end

  // Hardware updates of the return pointer win over a bus write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ret_ptr <= '0;
    end else if (state == ST_CALL_MEM && mem_ack_i) begin
      ret_ptr <= ret_ptr + STEP;
    end else if (take && !page_bad && op_code_i == OP_RET) begin
      ret_ptr <= ret_ptr - STEP;
    end else if (avs_write_i && avs_address_i == OFS_RPTR_LO) begin
      ret_ptr[31:0] <= be_merge(ret_ptr[31:0], avs_writedata_i,
                                avs_byteenable_i);
    end else if (XLEN == 64 && avs_write_i &&
                 avs_address_i == OFS_RPTR_HI) begin
      ret_ptr[XLEN-1 -: 32] <= be_merge(ret_ptr[XLEN-1 -: 32],
                                        avs_writedata_i, avs_byteenable_i);
    end
  end

  // ****************************************************************
  // Bus read path: one wait state per read
  // ****************************************************************
  assign avs_waitrequest_o = avs_read_i & ~rd_done;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_done        <= 1'b0;
      avs_readdata_o <= '0;
    end else begin
      rd_done <= avs_read_i & ~rd_done;
      if (avs_read_i && !rd_done) begin
        case (avs_address_i)
          OFS_CMP:     avs_readdata_o <= cmp_cfg;
          OFS_LOGIC:   avs_readdata_o <= logic_cfg;
          OFS_ARITH:   avs_readdata_o <= arith_cfg;
          OFS_RPTR_LO: avs_readdata_o <= ret_ptr[31:0];
          OFS_RPTR_HI:
            avs_readdata_o <= (XLEN == 64) ? ret_ptr[XLEN-1 -: 32] : '0;
          default:     avs_readdata_o <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_CALL_WRITE: assert property (
    take && op_code_i == OP_CALL && !page_bad |=> mem_req_o && mem_we_o
      && mem_addr_o == $past(ret_ptr) && mem_wdata_o == $past(next_ip_i))
    else $error("call did not write next address at pointer");

  AST_CALL_INC: assert property (
    state == ST_CALL_MEM && mem_ack_i |=>
      ret_ptr == $past(ret_ptr) + STEP && op_ready_o)
    else $error("call did not advance return pointer");

  AST_RET_ADDR: assert property (
    take && op_code_i == OP_RET && !page_bad |=> mem_req_o && !mem_we_o
      && ret_ptr == $past(ret_ptr) - STEP && mem_addr_o == ret_ptr)
    else $error("return did not step pointer back first");

  AST_RET_LOAD: assert property (
    state == ST_RET_MEM && mem_ack_i |=>
      ip_load_o && ip_value_o == $past(mem_rdata_i))
    else $error("return did not load instruction pointer");

  AST_PAGE_FAULT: assert property (
    take && (op_code_i == OP_CALL || op_code_i == OP_RET) && page_bad
      && !avs_write_i
      |=> fault_page_perm_o && !mem_req_o && ret_ptr == $past(ret_ptr))
    else $error("missing page permission fault");

  AST_CMP_EQ: assert property (
    take_cmp && !wr_cmp && cmp_cfg[CMP_EQ] && op_a_i == op_b_i
      |=> cmp_cfg[CMP_RES])
    else $error("equal compare not reported");

  AST_XNOR: assert property (
    take && op_code_i == OP_LOGIC && logic_cfg == 32'h00000003
      |=> target_we_o && target_data_o == ~($past(op_a_i) ^ $past(op_b_i)))
    else $error("NOT with XOR is not XNOR");

  AST_ADD_WRAP: assert property (
    take_arith && !wr_arith && arith_cfg == 32'h00000008
      && op_a_i == '1 && op_b_i == XLEN'(3)
      |=> target_data_o == XLEN'(2) && arith_cfg[AR_OVF])
    else $error("overflow wrap or flag wrong");

  AST_BAD_W32: assert property (
    take && bad_w |=> fault_bad_value_o && !target_we_o && !ext_we_o)
    else $error("bad width bit did not fault");

  AST_EXT_NOFLAG: assert property (
    take_arith && ext_any && !wr_arith && !arith_cfg[AR_OVF]
      && !arith_cfg[AR_UNF] |=> !arith_cfg[AR_OVF] && !arith_cfg[AR_UNF])
    else $error("flag set with extended operand");

  AST_STICKY: assert property (
    arith_cfg[AR_OVF] && !wr_arith |=> arith_cfg[AR_OVF])
    else $error("overflow flag cleared without a write");

  AST_RD_WAIT: assert property (
    avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("read waited more than one cycle");

  COV_CALL: cover property (state == ST_CALL_MEM && mem_ack_i);
  COV_RET:  cover property (ip_load_o);
  COV_OVF:  cover property (take_arith && ovf);
  COV_CMP:  cover property (take_cmp && cmp_hit);

endmodule

// file: rtl/alu_flags_pkg.sv
package alu_flags_pkg;

  // ****************************************************************
  // Bus map
  // ****************************************************************
  localparam int          ADDR_W       = 6;
  localparam logic [5:0]  OFS_CMP      = 6'h00;
  localparam logic [5:0]  OFS_LOGIC    = 6'h04;
  localparam logic [5:0]  OFS_ARITH    = 6'h08;
  localparam logic [5:0]  OFS_RPTR_LO  = 6'h0C;
  localparam logic [5:0]  OFS_RPTR_HI  = 6'h10;
  localparam logic [31:0] CFG_RESET    = 32'h00000000;

  // ****************************************************************
  // Writable bits; the rest read as zero
  // ****************************************************************
  localparam logic [31:0] CMP_WMASK    = 32'h0000001F;
  localparam logic [31:0] LOGIC_WMASK  = 32'h000700FF;
  localparam logic [31:0] ARITH_WMASK  = 32'h0007FFFF;

  // ****************************************************************
  // Compare condition bits
  // ****************************************************************
  localparam int CMP_RES  = 0;
  localparam int CMP_NE   = 1;
  localparam int CMP_GT   = 2;
  localparam int CMP_LT   = 3;
  localparam int CMP_EQ   = 4;

  // ****************************************************************
  // Logic operation bits
  // ****************************************************************
  localparam int LG_NOT   = 0;
  localparam int LG_XOR   = 1;
  localparam int LG_AND   = 2;
  localparam int LG_OR    = 3;
  localparam int LG_SHL   = 4;
  localparam int LG_SHR   = 5;
  localparam int LG_ROL   = 6;
  localparam int LG_ROR   = 7;

  // ****************************************************************
  // Arithmetic operation bits
  // ****************************************************************
  localparam int AR_MUL   = 0;
  localparam int AR_DIV   = 1;
  localparam int AR_SUB   = 2;
  localparam int AR_ADD   = 3;
  localparam int AR_MOD   = 4;
  localparam int AR_SGN   = 5;
  localparam int AR_OVF   = 6;
  localparam int AR_UNF   = 7;
  localparam int AR_EXT   = 8;
  localparam int EXT_N    = 8;

  // Width restriction bits, shared by logic and arithmetic
  localparam int W8_BIT   = 16;
  localparam int W16_BIT  = 17;
  localparam int W32_BIT  = 18;

  // Return pointer step in bytes per variant
  localparam int STEP_32  = 4;
  localparam int STEP_64  = 8;

  typedef enum logic [2:0] {
    OP_CALL,
    OP_RET,
    OP_CMP,
    OP_LOGIC,
    OP_ARITH
  } op_e;

endpackage

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import alu_flags_pkg::*;
  // ********
  // Stimulus and observed signals
  // ********
  logic        clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [5:0]  avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, op_a_i = 0, op_b_i = 0;
  logic [31:0] next_ip_i = 32'h00001234, mem_rdata_i = 0;
  logic        op_valid_i = 0, op_alu_regs_i = 0, paging_en_i = 0;
  logic        page_read_only_i = 0, mem_ack_i = 0;
  op_e         op_code_i = OP_CMP;
  logic        avs_waitrequest_o, op_ready_o, op_done_o, target_we_o;
  logic        ext_we_o, ip_load_o, fault_bad_value_o, fault_page_perm_o;
  logic        mem_req_o, mem_we_o, tw, ew, ipl, fb, fp, m_we;
  logic [7:0]  ext_sel_o, es;
  logic [31:0] target_data_o, ext_data_o, ip_value_o, mem_addr_o;
  logic [31:0] mem_wdata_o, td, ed, ipv, m_a, m_d, rv;
  logic [31:0] le [8] = '{32'h7FFFFFF0, 32'h8000000B, 32'h00000004,
    32'h8000000F, 32'h000000F0, 32'h08000000, 32'h000000F8, 32'hF8000000};
  logic [31:0] ae [5] = '{32'h2BC, 32'hE, 32'h5D, 32'h6B, 32'h2};
  int          n_fail = 0, checks = 0;

  alu_control_flags uut (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
    .avs_waitrequest_o, .op_valid_i, .op_code_i, .op_a_i, .op_b_i,
    .op_alu_regs_i, .next_ip_i, .paging_en_i, .page_read_only_i, .op_ready_o,
    .op_done_o, .target_we_o, .target_data_o, .ext_we_o, .ext_sel_o,
    .ext_data_o, .ip_load_o, .ip_value_o, .fault_bad_value_o,
    .fault_page_perm_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
    .mem_ack_i, .mem_rdata_i);

  always #5 clk_i = ~clk_i;

  // Slow memory; data is junk outside the ack cycle
  always @(posedge clk_i) begin
    mem_ack_i <= mem_req_o & ~mem_ack_i;
    mem_rdata_i <= (mem_req_o & ~mem_ack_i) ? 32'h0000ABCD : 32'hFFFF5432;
    if (mem_req_o & ~mem_ack_i)
      {m_we, m_a, m_d} <= {mem_we_o, mem_addr_o, mem_wdata_o};
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  // Request holds until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rv = avs_readdata_o;
    avs_write_i <= 0;
    avs_read_i <= 0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(rv, e);
  endtask

  task automatic op(input op_e c, input logic [31:0] a, input logic [31:0] b,
                    input logic alu);
    int n;
    @(posedge clk_i);
    op_code_i <= c;
    op_a_i <= a;
    op_b_i <= b;
    op_alu_regs_i <= alu;
    op_valid_i <= 1;
    do @(posedge clk_i); while (op_ready_o !== 1'b1);
    op_valid_i <= 0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (op_done_o !== 1'b1 && n < 40);
    if (op_done_o !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t operation never finished", $time);
    end
    {tw, td, ew, es, ed, ipl, ipv, fb, fp} = {target_we_o, target_data_o,
      ext_we_o, ext_sel_o, ext_data_o, ip_load_o, ip_value_o,
      fault_bad_value_o, fault_page_perm_o};
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 0;
    rd(OFS_CMP, 0);
    rd(OFS_LOGIC, 0);
    rd(OFS_ARITH, 0);
    bus(1, 6'h14, 32'hFFFFFFFF);
    rd(6'h14, 0);
    bus(1, OFS_CMP, 32'h14);
    op(OP_CMP, 5, 3, 0);
    rd(OFS_CMP, 32'h15);
    op(OP_CMP, 2, 3, 0);
    rd(OFS_CMP, 32'h14);
    bus(1, OFS_CMP, 32'h02);
    op(OP_CMP, 2, 3, 0);
    rd(OFS_CMP, 32'h03);
    $display("compare test done");
    for (int i = 0; i < 8; i++) begin
      bus(1, OFS_LOGIC, 32'h1 << i);
      op(OP_LOGIC, 32'h8000000F, 4, 0);
      chk(td, le[i]);
    end
    bus(1, OFS_LOGIC, 32'h05);
    op(OP_LOGIC, 32'hFF00FF00, 32'hF0F0F0F0, 0);
    chk(td, 32'h0FFF0FFF);
    chkb(tw, 1'b1);
    bus(1, OFS_LOGIC, 32'h03);
    op(OP_LOGIC, 32'hFF00FF00, 32'hF0F0F0F0, 0);
    chk(td, 32'hF00FF00F);
    bus(1, OFS_LOGIC, 32'h10002);
    op(OP_LOGIC, 32'h12345678, 32'h0000FFFF, 1);
    chk(td, 32'h12345687);
    op(OP_LOGIC, 32'h12345678, 32'h0000FFFF, 0);
    chk(td, 32'h1234A987);
    bus(1, OFS_LOGIC, 32'h40002);
    op(OP_LOGIC, 1, 1, 1);
    chkb(fb, 1'b1);
    chkb(tw, 1'b0);
    $display("logic test done");
    for (int i = 0; i < 5; i++) begin
      bus(1, OFS_ARITH, 32'h1 << i);
      op(OP_ARITH, 100, 7, 0);
      chk(td, ae[i]);
    end
    bus(1, OFS_ARITH, 32'h08);
    op(OP_ARITH, 32'hFFFFFFFF, 3, 0);
    chk(td, 2);
    rd(OFS_ARITH, 32'h48);
    op(OP_ARITH, 1, 1, 0);
    rd(OFS_ARITH, 32'h48);
    bus(1, OFS_ARITH, 32'h04);
    op(OP_ARITH, 0, 3, 0);
    chk(td, 32'hFFFFFFFD);
    rd(OFS_ARITH, 32'h84);
    bus(1, OFS_ARITH, 32'h28);
    op(OP_ARITH, 32'hFFFFFFFF, 1, 0);
    rd(OFS_ARITH, 32'h28);
    bus(1, OFS_ARITH, 32'h101);
    op(OP_ARITH, 32'h80000000, 4, 0);
    chkb(ew, 1'b1);
    chk({24'h0, es}, 32'h01);
    chk(td, 32'h0);
    chk(ed, 32'h2);
    rd(OFS_ARITH, 32'h101);
    bus(1, OFS_ARITH, 32'h10008);
    op(OP_ARITH, 32'h123456FF, 1, 1);
    chk(td, 32'h12345600);
    $display("arithmetic test done");
    bus(1, OFS_RPTR_LO, 32'h100);
    op(OP_CALL, 0, 0, 0);
    chkb(m_we, 1'b1);
    chk(m_a, 32'h100);
    chk(m_d, 32'h1234);
    rd(OFS_RPTR_LO, 32'h104);
    op(OP_RET, 0, 0, 0);
    chkb(ipl, 1'b1);
    chk(ipv, 32'hABCD);
    chkb(m_we, 1'b0);
    chk(m_a, 32'h100);
    @(posedge clk_i) paging_en_i <= 1;
    op(OP_CALL, 0, 0, 0);
    chkb(fp, 1'b1);
    @(posedge clk_i) page_read_only_i <= 1;
    op(OP_CALL, 0, 0, 0);
    chkb(fp, 1'b0);
    $display("return pointer test done");
    results;
  end

  // Whole run takes a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    results;
  end
endmodule
